// file: inc/bcdat_pkg.sv
// Notes on behaviour
// (RQ1) Adjust after addition: 4 clocks, 1 byte, updates auxiliary-carry and carry.
// (RQ2) Adjust before division: 60 clocks, 2 bytes, sign, zero, parity from result.
// (RQ3) Adjust after subtraction: 4 clocks, 1 byte, updates auxiliary-carry and carry.
// (RQ4) Add, carry-add, AND: 3/4 clocks, memory forms 9, 16, 17 plus address time.
// (RQ5) Carry-add sums both operands and carry in; both adds set all six flags.
// (RQ6) AND clears overflow and carry, sets sign, zero, parity from result.
// (RQ7) Byte-to-word sign extension: 2 clocks, 1 byte, no transfer, flags unchanged.
// (RQ8) Wide bus: each odd-address word transfer adds four clocks.
// (RQ9) Narrow bus: every word transfer adds four clocks whatever its alignment.
// (RQ10) Address time 6, 5, up to 12 by components, plus 2 for segment override.
// (RQ11) Total count reported is base plus address time plus transfer penalties.
package bcdat_pkg;

	typedef enum logic [2:0] {
		op_ascii_adjust_after_addition,
		op_ascii_adjust_before_division,
		op_ascii_adjust_after_subtraction,
		op_add,
		op_add_with_carry,
		op_and,
		op_sign_extend_byte_op
	} bcdat_op_e;

	typedef enum logic [2:0] {
		form_reg_reg,
		form_reg_mem,
		form_mem_reg,
		form_reg_imm,
		form_mem_imm,
		form_acc_imm
	} bcdat_form_e;

	typedef enum logic [2:0] {
		ea_disp_only,
		ea_base_or_index,
		ea_disp_base_or_index,
		ea_bp_di_bx_si,
		ea_bp_si_bx_di,
		ea_bp_di_bx_si_disp,
		ea_bp_si_bx_di_disp
	} bcdat_ea_e;

	// Base clock figures per instruction and operand form.
	localparam logic [7:0] CLK_ADJ_ADD = 8'h04;
	localparam logic [7:0] CLK_ADJ_DIV = 8'h3C;
	localparam logic [7:0] CLK_ADJ_SUB = 8'h04;
	localparam logic [7:0] CLK_SEXT = 8'h02;
	localparam logic [7:0] CLK_REG_REG = 8'h03;
	localparam logic [7:0] CLK_REG_IMM = 8'h04;
	localparam logic [7:0] CLK_REG_MEM = 8'h09;
	localparam logic [7:0] CLK_MEM_REG = 8'h10;
	localparam logic [7:0] CLK_MEM_IMM = 8'h11;

	// Effective address times by component mix.
	localparam logic [7:0] EA_DISP = 8'h06;
	localparam logic [7:0] EA_BASE_IDX = 8'h05;
	localparam logic [7:0] EA_DISP_BI = 8'h09;
	localparam logic [7:0] EA_BPDI = 8'h07;
	localparam logic [7:0] EA_BPSI = 8'h08;
	localparam logic [7:0] EA_BPDI_DISP = 8'h0B;
	localparam logic [7:0] EA_BPSI_DISP = 8'h0C;
	localparam logic [7:0] EA_SEG_OVR = 8'h02;

	// Extra clocks per penalised word transfer, and transfers per memory form.
	localparam logic [7:0] WORD_PENALTY = 8'h04;
	localparam logic [1:0] XFER_NONE = 2'h0;
	localparam logic [1:0] XFER_MEM_SRC = 2'h1;
	localparam logic [1:0] XFER_MEM_DST = 2'h2;

	// Opcode byte counts; variable-length forms report their shortest encoding.
	localparam logic [2:0] BYTES_ONE = 3'h1;
	localparam logic [2:0] BYTES_TWO = 3'h2;
	localparam logic [2:0] BYTES_THREE = 3'h3;

	// Flag vector layout.
	localparam int FLG_W = 6;
	localparam int FLG_C = 0;
	localparam int FLG_P = 1;
	localparam int FLG_A = 2;
	localparam int FLG_Z = 3;
	localparam int FLG_S = 4;
	localparam int FLG_O = 5;

	// Decimal adjust constants.
	localparam logic [3:0] BCD_MAX_DIGIT = 4'h9;
	localparam logic [7:0] BCD_FIX = 8'h06;
	localparam logic [7:0] BCD_RADIX = 8'h0A;
	localparam logic [7:0] LOW_NIBBLE = 8'h0F;

endpackage

// file: inc/bcdat_cost_if.sv
`timescale 1ns/1ps
`default_nettype none
// Carries one instruction description to the cost calculator and its figures back.
interface bcdat_cost_if;
	bcdat_pkg::bcdat_op_e op;
	bcdat_pkg::bcdat_form_e form;
	bcdat_pkg::bcdat_ea_e ea;
	logic seg_ovr;
	logic word;
	logic odd_addr;
	logic bus8;
	logic [7:0] total;
	logic [2:0] bytes;

	modport calc (input op, input form, input ea, input seg_ovr, input word,
		input odd_addr, input bus8, output total, output bytes);
	modport user (output op, output form, output ea, output seg_ovr, output word,
		output odd_addr, output bus8, input total, input bytes);
endinterface
`default_nettype wire

// file: hdl/bcdat_cost.sv
`timescale 1ns/1ps
`default_nettype none
// Pure timing calculator; kept apart so the cost tables stay out of the datapath.
module bcdat_cost (
	bcdat_cost_if.calc cif
);

	// Address time, including the segment override surcharge.
	function automatic logic [7:0] ea_time(input bcdat_pkg::bcdat_ea_e ea, input logic seg);
		logic [7:0] t;
		t = bcdat_pkg::EA_DISP;
		unique case (ea)
			bcdat_pkg::ea_disp_only: t = bcdat_pkg::EA_DISP; // [RQ10]
			bcdat_pkg::ea_base_or_index: t = bcdat_pkg::EA_BASE_IDX; // [RQ10]
			bcdat_pkg::ea_disp_base_or_index: t = bcdat_pkg::EA_DISP_BI;
			bcdat_pkg::ea_bp_di_bx_si: t = bcdat_pkg::EA_BPDI;
			bcdat_pkg::ea_bp_si_bx_di: t = bcdat_pkg::EA_BPSI;
			bcdat_pkg::ea_bp_di_bx_si_disp: t = bcdat_pkg::EA_BPDI_DISP;
			bcdat_pkg::ea_bp_si_bx_di_disp: t = bcdat_pkg::EA_BPSI_DISP; // [RQ10]
			default: t = bcdat_pkg::EA_DISP;
		endcase
		if (seg) begin
			t = t + bcdat_pkg::EA_SEG_OVR; // [RQ10]
		end
		return t;
	endfunction

	logic [7:0] base;
	logic [1:0] xfer;
	logic mem_op;
	logic [7:0] penalty;

	// Base figure and memory traffic per instruction and form.
	always_comb begin
		base = bcdat_pkg::CLK_REG_REG;
		xfer = bcdat_pkg::XFER_NONE;
		mem_op = 1'b0;
		cif.bytes = bcdat_pkg::BYTES_TWO;
		unique case (cif.op)
			bcdat_pkg::op_ascii_adjust_after_addition: begin
				base = bcdat_pkg::CLK_ADJ_ADD; // [RQ1]
				cif.bytes = bcdat_pkg::BYTES_ONE; // [RQ1]
			end
			bcdat_pkg::op_ascii_adjust_before_division: begin
				base = bcdat_pkg::CLK_ADJ_DIV; // [RQ2]
				cif.bytes = bcdat_pkg::BYTES_TWO; // [RQ2]
			end
			bcdat_pkg::op_ascii_adjust_after_subtraction: begin
				base = bcdat_pkg::CLK_ADJ_SUB; // [RQ3]
				cif.bytes = bcdat_pkg::BYTES_ONE; // [RQ3]
			end
			bcdat_pkg::op_sign_extend_byte_op: begin
				base = bcdat_pkg::CLK_SEXT; // [RQ7]
				cif.bytes = bcdat_pkg::BYTES_ONE; // [RQ7]
			end
			default: begin
				unique case (cif.form)
					bcdat_pkg::form_reg_reg: base = bcdat_pkg::CLK_REG_REG; // [RQ4]
					bcdat_pkg::form_reg_mem: begin
						base = bcdat_pkg::CLK_REG_MEM; // [RQ4]
						xfer = bcdat_pkg::XFER_MEM_SRC;
						mem_op = 1'b1;
					end
					bcdat_pkg::form_mem_reg: begin
						base = bcdat_pkg::CLK_MEM_REG; // [RQ4]
						xfer = bcdat_pkg::XFER_MEM_DST;
						mem_op = 1'b1;
					end
					bcdat_pkg::form_mem_imm: begin
						base = bcdat_pkg::CLK_MEM_IMM; // [RQ4]
						xfer = bcdat_pkg::XFER_MEM_DST;
						mem_op = 1'b1;
						cif.bytes = bcdat_pkg::BYTES_THREE;
					end
					bcdat_pkg::form_reg_imm: begin
						base = bcdat_pkg::CLK_REG_IMM; // [RQ4]
						cif.bytes = bcdat_pkg::BYTES_THREE;
					end
					default: base = bcdat_pkg::CLK_REG_IMM; // [RQ4]
				endcase
			end
		endcase
	end

	// The narrow bus pays on every word transfer, the wide one only when misaligned.
	always_comb begin
		penalty = 8'h00;
		if (cif.word && (cif.bus8 || cif.odd_addr)) begin // [RQ8] [RQ9]
			penalty = 8'(xfer) * bcdat_pkg::WORD_PENALTY;
		end
		cif.total = base + (mem_op ? ea_time(cif.ea, cif.seg_ovr) : 8'h00) + penalty; // [RQ11]
	end

endmodule
`default_nettype wire

// file: hdl/bcdat_top.sv
`timescale 1ns/1ps
`default_nettype none
// Execution unit slice: computes result and flags at once, then holds them back
// until the documented clock count has elapsed so a timing model can track it.
module bcdat_top #(
	parameter int CYC_W = 8
) (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic start_in,
	input wire bcdat_pkg::bcdat_op_e op_in,
	input wire bcdat_pkg::bcdat_form_e form_in,
	input wire bcdat_pkg::bcdat_ea_e ea_in,
	input wire logic seg_override_in,
	input wire logic word_in,
	input wire logic odd_addr_in,
	input wire logic bus8_in,
	input wire logic [15:0] dest_in,
	input wire logic [15:0] src_in,
	input wire logic [bcdat_pkg::FLG_W-1:0] flags_in,
	output logic busy_out,
	output logic done_out,
	output logic [15:0] result_out,
	output logic [bcdat_pkg::FLG_W-1:0] flags_out,
	output logic [CYC_W-1:0] cycles_out,
	output logic [2:0] bytes_out
);

	// The longest figure is 60 clocks; counters narrower than 7 bits are refused.
	if (CYC_W < 7) begin : g_cyc_w_check
		$error("CYC_W too small for the longest instruction");
	end

	typedef struct packed {
		logic busy;
		logic done;
		logic [CYC_W-1:0] cnt;
		bcdat_pkg::bcdat_op_e op;
		logic [15:0] pend_res;
		logic [bcdat_pkg::FLG_W-1:0] pend_flags;
		logic [CYC_W-1:0] pend_cycles;
		logic [2:0] pend_bytes;
		logic [15:0] result;
		logic [bcdat_pkg::FLG_W-1:0] flags;
		logic [CYC_W-1:0] cycles;
		logic [2:0] bytes;
	} bcdat_state_s;

	bcdat_state_s s_reg;
	bcdat_state_s s_next;
	logic start_ok;
	logic [15:0] res;
	logic [bcdat_pkg::FLG_W-1:0] fl;

	bcdat_cost_if cif ();

	assign cif.op = op_in;
	assign cif.form = form_in;
	assign cif.ea = ea_in;
	assign cif.seg_ovr = seg_override_in;
	assign cif.word = word_in;
	assign cif.odd_addr = odd_addr_in;
	assign cif.bus8 = bus8_in;

	bcdat_cost u_cost (
		.cif(cif)
	);

	// Even parity over the low byte, as the flag is defined.
	function automatic logic parity8(input logic [7:0] v);
		return ~^v;
	endfunction

	// Sign, zero and parity share one decode for byte and word results.
	function automatic logic [2:0] szp(input logic [15:0] r, input logic w);
		logic s;
		logic z;
		s = w ? r[15] : r[7];
		z = w ? (r == 16'h0000) : (r[7:0] == 8'h00);
		return {s, z, parity8(r[7:0])};
	endfunction

	// Datapath. Flags left undefined are passed through unchanged so no stale
	// garbage appears; software must not rely on them either way.
	always_comb begin
		logic [16:0] sum;
		logic [7:0] al;
		logic [7:0] ah;
		logic adj;
		logic cin;
		logic msb_d;
		logic msb_s;
		logic msb_r;
		sum = 17'h00000;
		al = dest_in[7:0];
		ah = dest_in[15:8];
		adj = 1'b0;
		cin = 1'b0;
		msb_d = 1'b0;
		msb_s = 1'b0;
		msb_r = 1'b0;
		res = dest_in;
		fl = flags_in;
		unique case (op_in)
			bcdat_pkg::op_ascii_adjust_after_addition,
			bcdat_pkg::op_ascii_adjust_after_subtraction: begin
				adj = (al[3:0] > bcdat_pkg::BCD_MAX_DIGIT) || flags_in[bcdat_pkg::FLG_A];
				if (adj && op_in == bcdat_pkg::op_ascii_adjust_after_addition) begin
					al = al + bcdat_pkg::BCD_FIX;
					ah = ah + 8'h01;
				end else if (adj) begin
					al = al - bcdat_pkg::BCD_FIX;
					ah = ah - 8'h01;
				end
				res = {ah, al & bcdat_pkg::LOW_NIBBLE};
				fl[bcdat_pkg::FLG_A] = adj; // [RQ1] [RQ3]
				fl[bcdat_pkg::FLG_C] = adj; // [RQ1] [RQ3]
			end
			bcdat_pkg::op_ascii_adjust_before_division: begin
				al = ah * bcdat_pkg::BCD_RADIX + al;
				res = {8'h00, al};
				{fl[bcdat_pkg::FLG_S], fl[bcdat_pkg::FLG_Z], fl[bcdat_pkg::FLG_P]} =
					szp(res, 1'b0); // [RQ2]
			end
			bcdat_pkg::op_add, bcdat_pkg::op_add_with_carry: begin
				cin = (op_in == bcdat_pkg::op_add_with_carry) && flags_in[bcdat_pkg::FLG_C];
				if (word_in) begin
					sum = {1'b0, dest_in} + {1'b0, src_in} + {16'h0000, cin}; // [RQ5]
					res = sum[15:0];
					fl[bcdat_pkg::FLG_C] = sum[16];
					msb_d = dest_in[15];
					msb_s = src_in[15];
					msb_r = res[15];
				end else begin
					sum = {9'h000, dest_in[7:0]} + {9'h000, src_in[7:0]} + {16'h0000, cin}; // [RQ5]
					res = {dest_in[15:8], sum[7:0]};
					fl[bcdat_pkg::FLG_C] = sum[8];
					msb_d = dest_in[7];
					msb_s = src_in[7];
					msb_r = res[7];
				end
				fl[bcdat_pkg::FLG_O] = (msb_d == msb_s) && (msb_r != msb_d); // [RQ5]
				fl[bcdat_pkg::FLG_A] = dest_in[4] ^ src_in[4] ^ res[4]; // [RQ5]
				{fl[bcdat_pkg::FLG_S], fl[bcdat_pkg::FLG_Z], fl[bcdat_pkg::FLG_P]} =
					szp(res, word_in); // [RQ5]
			end
			bcdat_pkg::op_and: begin
				res = word_in ? (dest_in & src_in) : {dest_in[15:8], dest_in[7:0] & src_in[7:0]};
				fl[bcdat_pkg::FLG_O] = 1'b0; // [RQ6]
				fl[bcdat_pkg::FLG_C] = 1'b0; // [RQ6]
				{fl[bcdat_pkg::FLG_S], fl[bcdat_pkg::FLG_Z], fl[bcdat_pkg::FLG_P]} =
					szp(res, word_in); // [RQ6]
			end
			bcdat_pkg::op_sign_extend_byte_op: begin
				res = {{8{dest_in[7]}}, dest_in[7:0]};
				fl = flags_in; // [RQ7]
			end
			default: begin
				res = dest_in;
				fl = flags_in;
			end
		endcase
	end

	assign start_ok = start_in && !s_reg.busy;

	// Sequencer: a start is taken only when idle; results appear with done after
	// exactly the computed cycle count. Requests while busy are dropped.
	always_comb begin
		s_next = s_reg;
		s_next.done = 1'b0;
		if (start_ok) begin
			s_next.busy = 1'b1;
			s_next.cnt = CYC_W'(cif.total); // [RQ11]
			s_next.op = op_in;
			s_next.pend_res = res;
			s_next.pend_flags = fl;
			s_next.pend_cycles = CYC_W'(cif.total); // [RQ11]
			s_next.pend_bytes = cif.bytes;
		end else if (s_reg.busy) begin
			s_next.cnt = s_reg.cnt - CYC_W'(1);
			if (s_reg.cnt == CYC_W'(1)) begin
				s_next.busy = 1'b0;
				s_next.done = 1'b1; // [RQ4]
				s_next.result = s_reg.pend_res;
				s_next.flags = s_reg.pend_flags;
				s_next.cycles = s_reg.pend_cycles;
				s_next.bytes = s_reg.pend_bytes;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign busy_out = s_reg.busy;
	assign done_out = s_reg.done;
	assign result_out = s_reg.result;
	assign flags_out = s_reg.flags;
	assign cycles_out = s_reg.cycles;
	assign bytes_out = s_reg.bytes;

	// Timing and flag checks. Done is registered at the Nth edge after the taking
	// edge, so a property sampling in the preponed region sees it one edge later.
	a_adj_add_time: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [RQ1]
		start_ok && op_in == bcdat_pkg::op_ascii_adjust_after_addition
		|-> ##5 done_out && cycles_out == CYC_W'(4) && bytes_out == 3'h1)
		else $error("adjust after addition timing wrong");
	a_adj_div_time: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [RQ2]
		start_ok && op_in == bcdat_pkg::op_ascii_adjust_before_division
		|-> ##61 done_out && cycles_out == CYC_W'(60) && bytes_out == 3'h2)
		else $error("adjust before division timing wrong");
	a_adj_sub_time: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [RQ3]
		start_ok && op_in == bcdat_pkg::op_ascii_adjust_after_subtraction
		|=> busy_out[*4] ##1 done_out && !busy_out)
		else $error("adjust after subtraction timing wrong");
	a_regreg_time: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [RQ4]
		start_ok && op_in == bcdat_pkg::op_and && form_in == bcdat_pkg::form_reg_reg
		|-> ##4 done_out && cycles_out == CYC_W'(3))
		else $error("register form timing wrong");
	a_adc_sum_byte: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [RQ5]
		start_ok && op_in == bcdat_pkg::op_add_with_carry && !word_in
		&& form_in == bcdat_pkg::form_reg_reg
		|-> ##4 result_out[7:0] == 8'($past(dest_in, 4) + $past(src_in, 4)
			+ {15'h0000, $past(flags_in[bcdat_pkg::FLG_C], 4)}))
		else $error("carry add sum wrong");
	a_and_flags_clear: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [RQ6]
		done_out && s_reg.op == bcdat_pkg::op_and
		|-> !flags_out[bcdat_pkg::FLG_O] && !flags_out[bcdat_pkg::FLG_C])
		else $error("AND left overflow or carry set");
	a_sext_flags_keep: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [RQ7]
		start_ok && op_in == bcdat_pkg::op_sign_extend_byte_op
		|-> ##3 done_out && flags_out == $past(flags_in, 3) && cycles_out == CYC_W'(2))
		else $error("sign extension timing or flags wrong");
	a_odd_word_cost: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [RQ8]
		start_ok && op_in == bcdat_pkg::op_add && form_in == bcdat_pkg::form_mem_reg
		&& ea_in == bcdat_pkg::ea_disp_only && !seg_override_in && word_in && !bus8_in
		|-> cif.total == (odd_addr_in ? 8'd30 : 8'd22))
		else $error("wide bus odd word penalty wrong");
	a_narrow_word_cost: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [RQ9]
		start_ok && op_in == bcdat_pkg::op_add && form_in == bcdat_pkg::form_reg_mem
		&& ea_in == bcdat_pkg::ea_base_or_index && !seg_override_in && bus8_in
		|-> cif.total == (word_in ? 8'd18 : 8'd14))
		else $error("narrow bus word penalty wrong");
	a_ea_seg_cost: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [RQ10]
		start_ok && op_in == bcdat_pkg::op_and && form_in == bcdat_pkg::form_reg_mem
		&& ea_in == bcdat_pkg::ea_bp_si_bx_di_disp && seg_override_in && !word_in
		|-> ##24 done_out && cycles_out == CYC_W'(23))
		else $error("address time with override wrong");

endmodule
`default_nettype wire

// file: dv/tb_bcd_adjust_add_logic_timing.sv
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench: each instruction is timed edge by edge and all its figures compared.
module tb_bcd_adjust_add_logic_timing;
	logic clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic start_in = 1'b0;
	bcdat_pkg::bcdat_op_e op_in = bcdat_pkg::op_add;
	bcdat_pkg::bcdat_form_e form_in = bcdat_pkg::form_reg_reg;
	bcdat_pkg::bcdat_ea_e ea_in = bcdat_pkg::ea_disp_only;
	logic seg_override_in = 1'b0;
	logic word_in = 1'b0;
	logic odd_addr_in = 1'b0;
	logic bus8_in = 1'b0;
	logic [15:0] dest_in = 16'h0000;
	logic [15:0] src_in = 16'h0000;
	logic [bcdat_pkg::FLG_W-1:0] flags_in = 6'h00;
	logic busy_out;
	logic done_out;
	logic [15:0] result_out;
	logic [bcdat_pkg::FLG_W-1:0] flags_out;
	logic [7:0] cycles_out;
	logic [2:0] bytes_out;
	int n_mismatch = 0;
	int checked = 0;
	int seed = 86;
	logic [7:0] ea_tab [0:6] = '{8'h06, 8'h05, 8'h09, 8'h07, 8'h08, 8'h0B, 8'h0C};

	// Free-running 100 MHz clock.
	always #5 clk_in = ~clk_in;

	bcdat_top #(.CYC_W(8)) bcdat_top_inst (
		.clk_in(clk_in), .sys_rst_in(sys_rst_in), .start_in(start_in), .op_in(op_in),
		.form_in(form_in), .ea_in(ea_in), .seg_override_in(seg_override_in),
		.word_in(word_in), .odd_addr_in(odd_addr_in), .bus8_in(bus8_in), .dest_in(dest_in),
		.src_in(src_in), .flags_in(flags_in), .busy_out(busy_out), .done_out(done_out),
		.result_out(result_out), .flags_out(flags_out), .cycles_out(cycles_out),
		.bytes_out(bytes_out)
	);

	// Verdict and end of run; every path to the end comes through here.
	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// One compare task per kind of result.
	task automatic chk_bit(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD bit at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_count(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD count at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_flags(input logic [5:0] got, input logic [5:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD flags at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_data(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD data at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	function automatic int rnd(input int n);
		return int'($unsigned($random(seed)) % n);
	endfunction

	// Base figure, plus address time and word penalties for memory forms.
	function automatic logic [7:0] exp_cycles(input bcdat_pkg::bcdat_op_e op,
		input bcdat_pkg::bcdat_form_e fm, input bcdat_pkg::bcdat_ea_e ea, input logic seg,
		input logic wd, input logic odd, input logic b8);
		logic [7:0] base;
		logic [7:0] xf;
		case (op)
			bcdat_pkg::op_ascii_adjust_after_addition: return 8'h04;
			bcdat_pkg::op_ascii_adjust_after_subtraction: return 8'h04;
			bcdat_pkg::op_ascii_adjust_before_division: return 8'h3C;
			bcdat_pkg::op_sign_extend_byte_op: return 8'h02;
			default: base = 8'h00;
		endcase
		if (fm == bcdat_pkg::form_reg_reg) return 8'h03;
		if (fm == bcdat_pkg::form_reg_imm || fm == bcdat_pkg::form_acc_imm) return 8'h04;
		base = (fm == bcdat_pkg::form_reg_mem) ? 8'h09 :
			(fm == bcdat_pkg::form_mem_reg) ? 8'h10 : 8'h11;
		xf = (fm == bcdat_pkg::form_reg_mem) ? 8'h01 : 8'h02;
		base = base + ea_tab[int'(ea)] + (seg ? 8'h02 : 8'h00);
		return base + ((wd && (b8 || odd)) ? 8'(xf * 8'h04) : 8'h00);
	endfunction

	function automatic logic [2:0] exp_bytes(input bcdat_pkg::bcdat_op_e op,
		input bcdat_pkg::bcdat_form_e fm);
		if (op == bcdat_pkg::op_ascii_adjust_before_division) return 3'h2;
		if (op inside {bcdat_pkg::op_add, bcdat_pkg::op_add_with_carry, bcdat_pkg::op_and})
			return (fm inside {bcdat_pkg::form_reg_imm, bcdat_pkg::form_mem_imm}) ? 3'h3 : 3'h2;
		return 3'h1;
	endfunction

	// Result in the low 16 bits, flags above; undefined flags pass through unchanged.
	function automatic logic [21:0] exp_res(input bcdat_pkg::bcdat_op_e op, input logic wd,
		input logic [15:0] d, input logic [15:0] s, input logic [5:0] f);
		logic [16:0] sum;
		logic [15:0] r;
		logic [5:0] fo;
		logic cin;
		logic w;
		logic alu;
		fo = f;
		r = d;
		alu = op inside {bcdat_pkg::op_add, bcdat_pkg::op_add_with_carry, bcdat_pkg::op_and};
		w = wd && alu;
		cin = (op == bcdat_pkg::op_add_with_carry) && f[0];
		if (op inside {bcdat_pkg::op_ascii_adjust_after_addition,
			bcdat_pkg::op_ascii_adjust_after_subtraction}) begin
			fo[0] = (d[3:0] > 4'h9) || f[2];
			fo[2] = fo[0];
			// High byte steps by one on adjust; low byte keeps only the digit.
			r[15:8] = fo[0] ? ((op == bcdat_pkg::op_ascii_adjust_after_addition) ?
				d[15:8] + 8'h01 : d[15:8] - 8'h01) : d[15:8];
			r[7:0] = {4'h0, fo[0] ? ((op == bcdat_pkg::op_ascii_adjust_after_addition) ?
				d[3:0] + 4'h6 : d[3:0] - 4'h6) : d[3:0]};
		end else if (op == bcdat_pkg::op_ascii_adjust_before_division) begin
			r = {8'h00, 8'(d[15:8] * 8'h0A + d[7:0])};
		end else if (op == bcdat_pkg::op_sign_extend_byte_op) begin
			r = {{8{d[7]}}, d[7:0]};
		end else if (op == bcdat_pkg::op_and) begin
			r = w ? (d & s) : {d[15:8], d[7:0] & s[7:0]};
			fo[0] = 1'b0;
			fo[5] = 1'b0;
		end else begin
			sum = {9'h000, d[7:0]} + {9'h000, s[7:0]} + 17'(cin);
			if (w) begin
				sum = {1'b0, d} + {1'b0, s} + 17'(cin);
			end
			r = w ? sum[15:0] : {d[15:8], sum[7:0]};
			fo[0] = w ? sum[16] : sum[8];
			fo[2] = ({1'b0, d[3:0]} + {1'b0, s[3:0]} + 5'(cin)) > 5'h0F;
			fo[5] = w ? (d[15] == s[15]) && (sum[15] != d[15]) : (d[7] == s[7]) && (sum[7] != d[7]);
		end
		if (alu || op == bcdat_pkg::op_ascii_adjust_before_division) begin
			fo[4] = w ? r[15] : r[7];
			fo[3] = w ? (r == 16'h0000) : (r[7:0] == 8'h00);
			fo[1] = ~^r[7:0];
		end
		return {fo, r};
	endfunction

	// Issues one instruction at a falling edge and follows it to completion.
	// Start stays high one extra edge while busy, and operands are scrambled, to prove
	// that a busy unit neither takes a second request nor resamples its inputs.
	task automatic run_op(input bcdat_pkg::bcdat_op_e op, input bcdat_pkg::bcdat_form_e fm,
		input bcdat_pkg::bcdat_ea_e ea, input logic seg, input logic wd, input logic odd,
		input logic b8, input logic [15:0] d, input logic [15:0] s, input logic [5:0] f);
		logic [7:0] ncyc;
		logic [21:0] er;
		int cnt;
		ncyc = exp_cycles(op, fm, ea, seg, wd, odd, b8);
		er = exp_res(op, wd, d, s, f);
		op_in = op;
		form_in = fm;
		ea_in = ea;
		seg_override_in = seg;
		word_in = wd;
		odd_addr_in = odd;
		bus8_in = b8;
		dest_in = d;
		src_in = s;
		flags_in = f;
		start_in = 1'b1;
		@(negedge clk_in);
		chk_bit(busy_out, 1'b1);
		chk_bit(done_out, 1'b0);
		dest_in = 16'(rnd(65536));
		src_in = 16'(rnd(65536));
		flags_in = 6'(rnd(64));
		word_in = ~wd;
		cnt = 0;
		while (done_out !== 1'b1 && cnt < 100) begin
			@(negedge clk_in);
			cnt++;
			if (cnt == 1) start_in = 1'b0;
		end
		if (cnt >= 100) begin
			n_mismatch++;
			print_verdict();
		end
		chk_count(8'(cnt), ncyc);
		chk_count(cycles_out, ncyc);
		chk_count({5'h00, bytes_out}, {5'h00, exp_bytes(op, fm)});
		chk_bit(busy_out, 1'b0);
		chk_flags(flags_out, er[21:16]);
		chk_data(result_out, er[15:0]);
	endtask

	// Reset, then corner cases, a sweep of every operation and form, then random traffic.
	initial begin
		repeat (3) @(negedge clk_in);
		chk_bit(busy_out | done_out, 1'b0);
		chk_data(result_out, 16'h0000);
		chk_count(cycles_out, 8'h00);
		sys_rst_in = 1'b0;
		@(negedge clk_in);
		run_op(bcdat_pkg::op_ascii_adjust_after_addition, bcdat_pkg::form_reg_reg,
			bcdat_pkg::ea_disp_only, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0109, 16'h0000, 6'h00);
		run_op(bcdat_pkg::op_ascii_adjust_after_addition, bcdat_pkg::form_reg_reg,
			bcdat_pkg::ea_disp_only, 1'b0, 1'b0, 1'b0, 1'b0, 16'h010A, 16'h0000, 6'h00);
		run_op(bcdat_pkg::op_ascii_adjust_after_subtraction, bcdat_pkg::form_reg_reg,
			bcdat_pkg::ea_disp_only, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0205, 16'h0000, 6'h04);
		run_op(bcdat_pkg::op_ascii_adjust_before_division, bcdat_pkg::form_reg_reg,
			bcdat_pkg::ea_disp_only, 1'b0, 1'b1, 1'b1, 1'b1, 16'h0909, 16'h0000, 6'h3F);
		run_op(bcdat_pkg::op_add, bcdat_pkg::form_reg_imm,
			bcdat_pkg::ea_disp_only, 1'b0, 1'b0, 1'b0, 1'b0, 16'hA57F, 16'h0001, 6'h00);
		run_op(bcdat_pkg::op_add_with_carry, bcdat_pkg::form_mem_reg,
			bcdat_pkg::ea_bp_si_bx_di_disp, 1'b1, 1'b1, 1'b1, 1'b0,
			16'hFFFF, 16'h0000, 6'h01);
		// Exact operand mixes that the cost, AND-flag and sign-extension properties of the design look for.
		run_op(bcdat_pkg::op_add, bcdat_pkg::form_mem_reg,
			bcdat_pkg::ea_disp_only, 1'b0, 1'b1, 1'b1, 1'b0, 16'h1234, 16'h4321, 6'h00);
		run_op(bcdat_pkg::op_add, bcdat_pkg::form_mem_reg,
			bcdat_pkg::ea_disp_only, 1'b0, 1'b1, 1'b0, 1'b0, 16'h7FFF, 16'h0001, 6'h00);
		run_op(bcdat_pkg::op_add, bcdat_pkg::form_reg_mem,
			bcdat_pkg::ea_base_or_index, 1'b0, 1'b1, 1'b0, 1'b1, 16'h00FF, 16'h0001, 6'h00);
		run_op(bcdat_pkg::op_add, bcdat_pkg::form_reg_mem,
			bcdat_pkg::ea_base_or_index, 1'b0, 1'b0, 1'b0, 1'b1, 16'h0080, 16'h0080, 6'h00);
		run_op(bcdat_pkg::op_and, bcdat_pkg::form_reg_mem,
			bcdat_pkg::ea_bp_si_bx_di_disp, 1'b1, 1'b0, 1'b0, 1'b0,
			16'h5AF0, 16'h0F0F, 6'h21);
		run_op(bcdat_pkg::op_and, bcdat_pkg::form_mem_imm,
			bcdat_pkg::ea_disp_only, 1'b0, 1'b1, 1'b0, 1'b1, 16'h8000, 16'hFFFF, 6'h3F);
		run_op(bcdat_pkg::op_sign_extend_byte_op, bcdat_pkg::form_mem_imm,
			bcdat_pkg::ea_disp_only, 1'b1, 1'b1, 1'b1, 1'b1, 16'h1280, 16'h0000, 6'h2A);
		for (int i = 0; i < 7; i++) begin
			for (int j = 0; j < 6; j++) begin
				run_op(bcdat_pkg::bcdat_op_e'(3'(i)), bcdat_pkg::bcdat_form_e'(3'(j)),
					bcdat_pkg::bcdat_ea_e'(3'(j + i % 2)), j[0], i[0], j[1], i[1],
					16'(rnd(65536)), 16'(rnd(65536)), 6'(rnd(64)));
			end
		end
		repeat (200) begin
			run_op(bcdat_pkg::bcdat_op_e'(3'(rnd(7))), bcdat_pkg::bcdat_form_e'(3'(rnd(6))),
				bcdat_pkg::bcdat_ea_e'(3'(rnd(7))), 1'(rnd(2)), 1'(rnd(2)), 1'(rnd(2)), 1'(rnd(2)),
				16'(rnd(65536)), 16'(rnd(65536)), 6'(rnd(64)));
		end
		@(negedge clk_in);
		chk_bit(done_out, 1'b0);
		print_verdict();
	end
endmodule
`default_nettype wire
